// file: design/imv_pkg.sv
/*
 * Shared constants for the indirect and literal move executor: instruction
 * field layout, opcode patterns, reset values and pointer update modes.
 * Assumes a 14-bit instruction word and an 8-bit data path.
 */
package imv_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int PTR_W = 16;
   localparam int BANK_W = 5;
   localparam int PAGE_W = 7;
   localparam int FILE_W = 7;
   localparam int OFFS_W = 6;

   // ****************************************************************
   // Opcode patterns, compared against the top bits of the word
   // ****************************************************************
   localparam logic [5:0] OP_LIT_ACC = 6'h30;       // Bits 13:8
   localparam logic [6:0] OP_LIT_PAGE = 7'h63;      // Bits 13:7
   localparam logic [8:0] OP_LIT_BANK = 9'h001;     // Bits 13:5
   localparam logic [6:0] OP_STORE_ACC = 7'h01;     // Bits 13:7
   localparam logic [10:0] OP_IND_MODE = 11'h002;   // Bits 13:3
   localparam logic [6:0] OP_IND_OFFS = 7'h7E;      // Bits 13:7

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int IND_MODE_SEL_BIT = 2;
   localparam int IND_OFFS_SEL_BIT = 6;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
   localparam logic [PAGE_W-1:0] PAGE_RST = 7'h00;
   localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;

   // Pointer update modes
   typedef enum logic [1:0] {
      MODE_PRE_INC = 2'b00,
      MODE_PRE_DEC = 2'b01,
      MODE_POST_INC = 2'b10,
      MODE_POST_DEC = 2'b11
   } imv_mode_e;

   // Executor states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_CAPT = 2'b10
   } imv_state_e;

endpackage

// file: design/imv_core.sv
/*
 * Executor for the indirect load, literal loads and accumulator store.
 * Assumes a data memory on the same clock that returns read data in the
 * cycle after the read strobe, and a fetch unit that honours ready.
 */
`timescale 1ns/100ps
module imv_core
   import imv_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Instruction stream
   input wire logic instr_valid_i,
   input wire logic [INSTR_W-1:0] instr_i,
   output logic instr_ready_o,
   // Data memory port
   output logic [PTR_W-1:0] mem_addr_o,
   output logic mem_rd_o,
   output logic mem_wr_o,
   output logic [DATA_W-1:0] mem_wdata_o,
   input wire logic [DATA_W-1:0] mem_rdata_i,
   // Architectural state
   output logic [DATA_W-1:0] accumulator_o,
   output logic zero_flag_o,
   output logic [BANK_W-1:0] bank_select_reg_o,
   output logic [PAGE_W-1:0] program_counter_high_latch_o,
   output logic [PTR_W-1:0] file_select_pointer0_o,
   output logic [PTR_W-1:0] file_select_pointer1_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   imv_state_e state_r, state_nxt;
   logic [DATA_W-1:0] acc_r, acc_nxt;
   logic zero_r, zero_nxt;
   logic [BANK_W-1:0] bank_r, bank_nxt;
   logic [PAGE_W-1:0] page_r, page_nxt;
   logic [PTR_W-1:0] ptr_r [2];
   logic [PTR_W-1:0] ptr_nxt [2];
   logic [PTR_W-1:0] addr_r, addr_nxt;
   logic rd_r, rd_nxt;
   logic wr_r, wr_nxt;
   logic [DATA_W-1:0] wdata_r, wdata_nxt;

   // ****************************************************************
   // Decode
   // ****************************************************************
   logic take;
   logic is_lit_acc, is_lit_page, is_lit_bank, is_store, is_ind_mode, is_ind_offs;
   logic ind_sel;
   logic [PTR_W-1:0] ind_ptr, ptr_inc, ptr_dec, offs_ext;
   imv_mode_e ind_mode;

   // New work only enters while no indirect read is in flight
   assign instr_ready_o = (state_r == ST_IDLE);
   assign take = instr_valid_i && instr_ready_o;

   // Opcode matches; unmatched words are ignored and leave all state alone
   assign is_lit_acc = (instr_i[13:8] == OP_LIT_ACC);
   assign is_lit_page = (instr_i[13:7] == OP_LIT_PAGE);
   assign is_lit_bank = (instr_i[13:5] == OP_LIT_BANK);
   assign is_store = (instr_i[13:7] == OP_STORE_ACC);
   assign is_ind_mode = (instr_i[13:3] == OP_IND_MODE);
   assign is_ind_offs = (instr_i[13:7] == OP_IND_OFFS);

   // Pointer select and mode fields
   assign ind_sel = is_ind_offs ? instr_i[IND_OFFS_SEL_BIT] : instr_i[IND_MODE_SEL_BIT];
   assign ind_mode = imv_mode_e'(instr_i[1:0]);
   assign ind_ptr = ptr_r[ind_sel];

   // Plain 16-bit arithmetic, so both directions wrap for free
   assign ptr_inc = ind_ptr + 16'h0001;
   assign ptr_dec = ind_ptr - 16'h0001;
   assign offs_ext = {{(PTR_W-OFFS_W){instr_i[OFFS_W-1]}}, instr_i[OFFS_W-1:0]};

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;
      acc_nxt = acc_r;
      zero_nxt = zero_r;
      bank_nxt = bank_r;
      page_nxt = page_r;
      ptr_nxt[0] = ptr_r[0];
      ptr_nxt[1] = ptr_r[1];
      addr_nxt = addr_r;
      rd_nxt = 1'b0;
      wr_nxt = 1'b0;
      wdata_nxt = wdata_r;
      unique case (state_r)
         ST_IDLE: begin
            if (take && is_lit_acc) begin
               acc_nxt = instr_i[DATA_W-1:0];
            end else if (take && is_lit_page) begin
               page_nxt = instr_i[PAGE_W-1:0];
            end else if (take && is_lit_bank) begin
               bank_nxt = instr_i[BANK_W-1:0];
            end else if (take && is_store) begin
               // Banked address: bank above the 7-bit file operand
               addr_nxt = PTR_W'({bank_r, instr_i[FILE_W-1:0]});
               wdata_nxt = acc_r;
               wr_nxt = 1'b1;
            end else if (take && is_ind_offs) begin
               addr_nxt = ind_ptr + offs_ext;
               rd_nxt = 1'b1;
               state_nxt = ST_READ;
            end else if (take && is_ind_mode) begin
               unique case (ind_mode)
                  MODE_PRE_INC: addr_nxt = ptr_inc;
                  MODE_PRE_DEC: addr_nxt = ptr_dec;
                  MODE_POST_INC: addr_nxt = ind_ptr;
                  MODE_POST_DEC: addr_nxt = ind_ptr;
               endcase
               // Both increments end at +1, both decrements at -1
               ptr_nxt[ind_sel] = ind_mode[0] ? ptr_dec : ptr_inc;
               rd_nxt = 1'b1;
               state_nxt = ST_READ;
            end
         end
         ST_READ: begin
            state_nxt = ST_CAPT;
         end
         ST_CAPT: begin
            // Data arrives the cycle after the strobe
            acc_nxt = mem_rdata_i;
            zero_nxt = (mem_rdata_i == '0);
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= ST_IDLE;
         acc_r <= ACC_RST;
         zero_r <= 1'b0;
         bank_r <= BANK_RST;
         page_r <= PAGE_RST;
         ptr_r[0] <= PTR_RST;
         ptr_r[1] <= PTR_RST;
         addr_r <= PTR_RST;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         wdata_r <= ACC_RST;
      end else begin
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         zero_r <= zero_nxt;
         bank_r <= bank_nxt;
         page_r <= page_nxt;
         ptr_r[0] <= ptr_nxt[0];
         ptr_r[1] <= ptr_nxt[1];
         addr_r <= addr_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         wdata_r <= wdata_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign mem_addr_o = addr_r;
   assign mem_rd_o = rd_r;
   assign mem_wr_o = wr_r;
   assign mem_wdata_o = wdata_r;
   assign accumulator_o = acc_r;
   assign zero_flag_o = zero_r;
   assign bank_select_reg_o = bank_r;
   assign program_counter_high_latch_o = page_r;
   assign file_select_pointer0_o = ptr_r[0];
   assign file_select_pointer1_o = ptr_r[1];

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_ind_load_acc: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mem_rd_o |-> ##2 (accumulator_o == $past(mem_rdata_i)
                        && zero_flag_o == ($past(mem_rdata_i) == 8'h00)))
      else $error("indirect load did not land in accumulator");

   a_ind_offs_addr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (take && is_ind_offs) |=> mem_rd_o && (mem_addr_o == $past(ind_ptr + offs_ext))
                                && (ptr_r[0] == $past(ptr_r[0])) && (ptr_r[1] == $past(ptr_r[1])))
      else $error("relative address or pointer hold wrong");

   a_pre_inc_addr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (take && is_ind_mode && instr_i[1:0] == 2'b00) |=>
         mem_addr_o == $past(ind_ptr) + 16'h0001 && mem_addr_o == ptr_r[$past(ind_sel)])
      else $error("pre-increment address wrong");

   a_post_dec_ptr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (take && is_ind_mode && instr_i[1:0] == 2'b11) |=>
         mem_addr_o == $past(ind_ptr) && ptr_r[$past(ind_sel)] == mem_addr_o - 16'h0001)
      else $error("post-decrement pointer wrong");

   a_ptr_wrap_top: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (take && is_ind_mode && !instr_i[0] && ind_ptr == 16'hFFFF) |=>
         ptr_r[$past(ind_sel)] == 16'h0000)
      else $error("pointer did not wrap at top");

   a_bank_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (take && is_lit_bank) |=> bank_select_reg_o == $past(instr_i[4:0]) && $stable(zero_flag_o))
      else $error("bank literal not loaded");

   a_page_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (take && is_lit_page) |=> program_counter_high_latch_o == $past(instr_i[6:0])
                                && $stable(zero_flag_o))
      else $error("page literal not loaded");

   a_acc_literal: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (take && is_lit_acc) |=> accumulator_o == $past(instr_i[7:0]) && instr_ready_o
                               && $stable(zero_flag_o))
      else $error("accumulator literal not one cycle");

   a_store_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (take && is_store) |=> mem_wr_o && mem_wdata_o == $past(acc_r)
                             && mem_addr_o[6:0] == $past(instr_i[6:0]) && instr_ready_o
                             ##1 !mem_wr_o || $past(take && is_store))
      else $error("store did not write accumulator");

endmodule // imv_core

// file: verif/imv_core_tb_top.sv
/*
 * Self-checking bench for the indirect and literal move executor.
 * Assumes imv_pkg and imv_core are compiled first; the bench stands in for
 * the fetch unit and a data memory with one cycle of read latency.
 */
`timescale 1ns/100ps
module imv_core_tb_top
   import imv_pkg::*;
;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic instr_valid_i = 1'b0;
   logic [INSTR_W-1:0] instr_i = '0;
   logic [DATA_W-1:0] mem_rdata_i = '0;
   logic instr_ready_o, mem_rd_o, mem_wr_o, zero_flag_o;
   logic [PTR_W-1:0] mem_addr_o, file_select_pointer0_o, file_select_pointer1_o;
   logic [DATA_W-1:0] mem_wdata_o, accumulator_o;
   logic [BANK_W-1:0] bank_select_reg_o;
   logic [PAGE_W-1:0] program_counter_high_latch_o;
   int error_cnt = 0;
   int checked = 0;
   logic [PTR_W-1:0] p0 = '0;
   logic [PTR_W-1:0] p1 = '0;
   logic rd_seen = 1'b0;

   imv_core i_imv_core (.clk_i(clk_i), .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .instr_ready_o(instr_ready_o), .mem_addr_o(mem_addr_o),
      .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
      .mem_rdata_i(mem_rdata_i), .accumulator_o(accumulator_o), .zero_flag_o(zero_flag_o),
      .bank_select_reg_o(bank_select_reg_o),
      .program_counter_high_latch_o(program_counter_high_latch_o),
      .file_select_pointer0_o(file_select_pointer0_o),
      .file_select_pointer1_o(file_select_pointer1_o));

   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;

   // ****************************************************************
   // Memory stand-in
   // ****************************************************************
   function automatic logic [7:0] mem_val(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h1F;
   endfunction

   // Strobe noted at one falling edge, data driven at the next, so it stands
   // in the cycle after the strobe; otherwise toggles so stale reads show
   always @(negedge clk_i) begin
      rd_seen <= mem_rd_o;
      mem_rdata_i <= rd_seen ? mem_val(mem_addr_o) : ~mem_rdata_i;
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Presents one word at a falling edge, returns at the next falling edge
   // with valid still up; the caller lowers it, so valid never drops and
   // rises again within one time step between back-to-back words
   task automatic issue(input logic [13:0] w);
      instr_valid_i = 1'b1;
      instr_i = w;
      @(posedge clk_i);
      @(negedge clk_i);
   endtask

   task automatic close_out();
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Indirect load; expectations worked out from the pointer copies here
   task automatic ind(input bit off, input logic sel, input logic [5:0] f);
      logic [15:0] p, a, np;
      logic [7:0] v;
      p = sel ? p1 : p0;
      if (off) begin
         a = p + {{10{f[5]}}, f};
         np = p;
      end else begin
         np = f[0] ? p - 16'h0001 : p + 16'h0001;
         a = f[1] ? p : np;
      end
      if (sel) p1 = np;
      else p0 = np;
      v = mem_val(a);
      issue(off ? {7'h7E, sel, f} : {11'h002, sel, f[1:0]});
      instr_valid_i = 1'b0;
      chk(mem_rd_o, 1'b1);
      chk(mem_addr_o, a);
      chk(file_select_pointer0_o, p0);
      chk(file_select_pointer1_o, p1);
      chk(instr_ready_o, 1'b0);
      @(negedge clk_i);
      chk(instr_ready_o, 1'b0);
      @(negedge clk_i);
      chk(accumulator_o, v);
      chk(zero_flag_o, v == 8'h00);
      chk(instr_ready_o, 1'b1);
   endtask

   task automatic test_indirect();
      ind(1'b1, 1'b1, 6'h1F);
      ind(1'b0, 1'b0, 6'h01);
      ind(1'b0, 1'b0, 6'h00);
      ind(1'b0, 1'b0, 6'h03);
      ind(1'b0, 1'b0, 6'h02);
      // Second pointer through the mode form, wrapping both ways
      ind(1'b0, 1'b1, 6'h03);
      ind(1'b0, 1'b1, 6'h02);
      ind(1'b1, 1'b1, 6'h20);
      $display("test_indirect done");
   endtask

   // Literals leave the zero flag at 1, as the last indirect load left it
   task automatic test_literals();
      logic [7:0] acc_tab [3] = '{8'h00, 8'hFF, 8'h5A};
      foreach (acc_tab[i]) begin
         issue({6'h30, acc_tab[i]});
         chk(accumulator_o, acc_tab[i]);
         chk(zero_flag_o, 1'b1);
      end
      issue({9'h001, 5'd31});
      chk(bank_select_reg_o, 5'd31);
      issue({9'h001, 5'd0});
      chk(bank_select_reg_o, 5'd0);
      issue({7'h63, 7'd127});
      chk(program_counter_high_latch_o, 7'd127);
      chk(zero_flag_o, 1'b1);
      // Back to back: one word each cycle
      instr_valid_i = 1'b1;
      instr_i = {6'h30, 8'h3C};
      @(posedge clk_i);
      @(negedge clk_i);
      chk(accumulator_o, 8'h3C);
      instr_i = {7'h63, 7'h00};
      @(posedge clk_i);
      @(negedge clk_i);
      instr_valid_i = 1'b0;
      chk(program_counter_high_latch_o, 7'h00);
      chk(zero_flag_o, 1'b1);
      @(negedge clk_i);
      $display("test_literals done");
   endtask

   task automatic store(input logic [4:0] b, input logic [6:0] f, input logic [7:0] w);
      issue({6'h30, w});
      issue({9'h001, b});
      issue({7'h01, f});
      instr_valid_i = 1'b0;
      chk(mem_wr_o, 1'b1);
      chk(mem_addr_o, {4'h0, b, f});
      chk(mem_wdata_o, w);
      chk(zero_flag_o, 1'b1);
      @(negedge clk_i);
      chk(mem_wr_o, 1'b0);
   endtask

   task automatic test_store();
      store(5'd31, 7'd127, 8'hA5);
      store(5'd0, 7'd0, 8'h00);
      $display("test_store done");
   endtask

   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      repeat (12) @(negedge clk_i);
      chk(instr_ready_o, 1'b1);
      chk(file_select_pointer0_o, 16'h0000);
      reset_n_i = 1'b1;
      @(negedge clk_i);
      test_indirect();
      test_literals();
      test_store();
      close_out();
   end

   initial begin
      #(25 * 2000);
      error_cnt++;
      close_out();
   end

endmodule // imv_core_tb_top
